// File: logic/slps_defines.vh
// Register map, field layout and state codes for the lane phy status block
`ifndef SLPS_DEFINES_VH
`define SLPS_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SLPS_OFS_CONFIG 12'h510
`define SLPS_OFS_CODING 12'h51c
`define SLPS_OFS_ELASTIC 12'h520
`define SLPS_OFS_IRQ_STATUS 12'h600
`define SLPS_OFS_IRQ_MASK 12'h604
`define SLPS_ADDR_W 12

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SLPS_LO_LSB 0
`define SLPS_HI_LSB 16
`define SLPS_SWING_BIT 16
`define SLPS_LANES 8
`define SLPS_HALF 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SLPS_RST_LANES 8'h00
`define SLPS_RST_BIT 1'h0
`define SLPS_RST_WORD 32'h0000_0000
`define SLPS_RST_IRQ 4'h0

// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define SLPS_IRQ_DISP 0
`define SLPS_IRQ_DEC 1
`define SLPS_IRQ_UND 2
`define SLPS_IRQ_OVR 3
`define SLPS_IRQ_W 4

// ----------------------------------------
// Training state codes on i_ltssm_state
// ----------------------------------------
`define SLPS_ST_W 4
`define SLPS_ST_DETECT 4'h0
`define SLPS_ST_POLLING 4'h1
`define SLPS_ST_CONFIG 4'h2
`define SLPS_ST_L0 4'h3
`define SLPS_ST_RECOVERY 4'h4
`define SLPS_ST_DISABLED 4'h5
`define SLPS_ST_HOT_RESET 4'h6

`endif

// File: logic/slps_lane_phy_regs.v
// Lane phy configuration and lane error status registers with APB slave
`include "slps_defines.vh"

module slps_lane_phy_regs #(
    parameter LANES = `SLPS_LANES,
    parameter ODD_PORT = 0
) (
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    input wire i_sw_rst,
    // APB slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [31:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire [3:0] i_pstrb,
    output reg [31:0] o_prdata,
    output reg o_pready,
    output reg o_pslverr,
    // Port mode
    input wire i_merged_mode,
    input wire i_serdes_test_mode,
    input wire [`SLPS_ST_W-1:0] i_ltssm_state,
    // Lane detection level and lane error events, one-cycle pulses
    input wire [LANES-1:0] i_rx_detected,
    input wire [LANES-1:0] i_disparity_err,
    input wire [LANES-1:0] i_decode_err,
    input wire [LANES-1:0] i_rx_underflow,
    input wire [LANES-1:0] i_rx_overflow,
    // Lane controls
    output reg [LANES-1:0] o_receiver_detected,
    output reg o_low_swing_select,
    output reg o_irq
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Lanes whose bits carry meaning for the current port mode
    function [LANES-1:0] lane_valid;
        input merged;
        integer k;
        begin
            lane_valid = {LANES{1'b0}};
            for (k = 0; k < LANES; k = k + 1) begin
                if (k < `SLPS_HALF) begin
                    lane_valid[k] = 1'b1;
                end else if (ODD_PORT == 0) begin
                    lane_valid[k] = merged;
                end
            end
        end
    endfunction

    // Write-one-to-clear with set winning over clear
    // Set beats clear
    function w1c_set;
        input cur;
        input clr;
        input set;
        begin
            w1c_set = (cur & ~clr) | set;
        end
    endfunction

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    // Offset compare, shared by every register select
    function is_ofs;
        input [`SLPS_ADDR_W-1:0] a;
        input [`SLPS_ADDR_W-1:0] ofs;
        begin
            is_ofs = (a == ofs);
        end
    endfunction

    wire [`SLPS_ADDR_W-1:0] addr = i_paddr[`SLPS_ADDR_W-1:0];
    wire hit_cfg = is_ofs(addr, `SLPS_OFS_CONFIG);
    wire hit_cod = is_ofs(addr, `SLPS_OFS_CODING);
    wire hit_ela = is_ofs(addr, `SLPS_OFS_ELASTIC);
    wire hit_ist = is_ofs(addr, `SLPS_OFS_IRQ_STATUS);
    wire hit_imk = is_ofs(addr, `SLPS_OFS_IRQ_MASK);
    wire hit_any = hit_cfg | hit_cod | hit_ela | hit_ist | hit_imk;
    // Offsets above the map and byte addresses inside a word are refused
    wire in_map = ~|i_paddr[31:`SLPS_ADDR_W];
    wire word_aligned = ~|i_paddr[1:0];
    wire aligned = in_map & word_aligned;
    // One wait state: a request is taken in its first access cycle only,
    // so the held second cycle neither clears flags again nor reloads data
    wire access = i_psel & i_penable & ~o_pready;
    wire good = hit_any & aligned;
    wire wr = access & i_pwrite & good;
    wire rd = access & ~i_pwrite & good;
    wire bad = access & ~good;
    // Byte lane 0 enables the low field, byte lane 2 the high field
    wire lo_lane = i_pstrb[0];
    wire hi_lane = i_pstrb[2];

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg [LANES-1:0] force_reg;
    reg swing_reg;
    reg [LANES-1:0] disp_reg;
    reg [LANES-1:0] dec_reg;
    reg [LANES-1:0] und_reg;
    reg [LANES-1:0] ovr_reg;
    reg [`SLPS_IRQ_W-1:0] ist_reg;
    reg [`SLPS_IRQ_W-1:0] imk_reg;
    // Lane flag next values come from the per-lane loop
    wire [LANES-1:0] disp_next;
    wire [LANES-1:0] dec_next;
    wire [LANES-1:0] und_next;
    wire [LANES-1:0] ovr_next;
    reg [`SLPS_IRQ_W-1:0] ist_next;
    reg [31:0] rdata;

    wire [LANES-1:0] valid = lane_valid(i_merged_mode);
    wire [LANES-1:0] clr_lo = i_pwdata[`SLPS_LO_LSB +: LANES] & {LANES{wr & lo_lane}};
    wire [LANES-1:0] clr_hi = i_pwdata[`SLPS_HI_LSB +: LANES] & {LANES{wr & hi_lane}};

    // ----------------------------------------
    // Training state gating
    // ----------------------------------------
    // Gate to L0; decode errors also count in Configuration, Disabled and Hot Reset
    wire in_l0 = (i_ltssm_state == `SLPS_ST_L0);
    wire dec_ok = in_l0 || (i_ltssm_state == `SLPS_ST_CONFIG) ||
                  (i_ltssm_state == `SLPS_ST_DISABLED) ||
                  (i_ltssm_state == `SLPS_ST_HOT_RESET);

    wire [LANES-1:0] set_disp = i_disparity_err & valid & {LANES{in_l0}};
    wire [LANES-1:0] set_dec = i_decode_err & valid & {LANES{dec_ok}};
    wire [LANES-1:0] set_und = i_rx_underflow & valid & {LANES{in_l0}};
    wire [LANES-1:0] set_ovr = i_rx_overflow & valid & {LANES{in_l0}};

    // ----------------------------------------
    // Status next state
    // ----------------------------------------
    // Clears are steered to the word that was written
    wire [LANES-1:0] clr_disp = hit_cod ? clr_lo : {LANES{1'b0}};
    wire [LANES-1:0] clr_dec = hit_cod ? clr_hi : {LANES{1'b0}};
    wire [LANES-1:0] clr_und = hit_ela ? clr_lo : {LANES{1'b0}};
    wire [LANES-1:0] clr_ovr = hit_ela ? clr_hi : {LANES{1'b0}};

    // Every lane keeps its own four flags
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : g_lane
            assign disp_next[g] = w1c_set(disp_reg[g], clr_disp[g], set_disp[g]);
            assign dec_next[g] = w1c_set(dec_reg[g], clr_dec[g], set_dec[g]);
            assign und_next[g] = w1c_set(und_reg[g], clr_und[g], set_und[g]);
            assign ovr_next[g] = w1c_set(ovr_reg[g], clr_ovr[g], set_ovr[g]);
        end
    endgenerate

    always @* begin
        ist_next = ist_reg;
        if (wr && hit_ist && lo_lane) begin
            ist_next = ist_reg & ~i_pwdata[`SLPS_IRQ_W-1:0];
        end
        ist_next[`SLPS_IRQ_DISP] = ist_next[`SLPS_IRQ_DISP] | (|set_disp);
        ist_next[`SLPS_IRQ_DEC] = ist_next[`SLPS_IRQ_DEC] | (|set_dec);
        ist_next[`SLPS_IRQ_UND] = ist_next[`SLPS_IRQ_UND] | (|set_und);
        ist_next[`SLPS_IRQ_OVR] = ist_next[`SLPS_IRQ_OVR] | (|set_ovr);
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    // Reserved bits and unmapped offsets read as zero
    always @* begin
        rdata = `SLPS_RST_WORD;
        case (addr)
            `SLPS_OFS_CONFIG: begin
                rdata[`SLPS_LO_LSB +: LANES] = force_reg;
                rdata[`SLPS_SWING_BIT] = swing_reg;
            end
            `SLPS_OFS_CODING: begin
                rdata[`SLPS_LO_LSB +: LANES] = disp_reg;
                rdata[`SLPS_HI_LSB +: LANES] = dec_reg;
            end
            `SLPS_OFS_ELASTIC: begin
                rdata[`SLPS_LO_LSB +: LANES] = und_reg;
                rdata[`SLPS_HI_LSB +: LANES] = ovr_reg;
            end
            `SLPS_OFS_IRQ_STATUS: begin
                rdata[`SLPS_IRQ_W-1:0] = ist_reg;
            end
            `SLPS_OFS_IRQ_MASK: begin
                rdata[`SLPS_IRQ_W-1:0] = imk_reg;
            end
            default: begin
                rdata = `SLPS_RST_WORD;
            end
        endcase
    end

    // ----------------------------------------
    // Configuration, sticky across software reset
    // ----------------------------------------
    // Store force field
    always @(posedge i_clk) begin
        if (i_rst) begin
            force_reg <= `SLPS_RST_LANES;
        end else if (wr && hit_cfg && lo_lane) begin
            force_reg <= i_pwdata[`SLPS_LO_LSB +: LANES];
        end
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            swing_reg <= `SLPS_RST_BIT;
        end else if (wr && hit_cfg && hi_lane) begin
            swing_reg <= i_pwdata[`SLPS_SWING_BIT];
        end
    end

    // ----------------------------------------
    // Status and interrupt registers
    // ----------------------------------------
    // Software reset clears status but not the configuration word
    always @(posedge i_clk) begin
        if (i_rst || i_sw_rst) begin
            disp_reg <= `SLPS_RST_LANES;
            dec_reg <= `SLPS_RST_LANES;
            und_reg <= `SLPS_RST_LANES;
            ovr_reg <= `SLPS_RST_LANES;
            ist_reg <= `SLPS_RST_IRQ;
        end else begin
            disp_reg <= disp_next;
            dec_reg <= dec_next;
            und_reg <= und_next;
            ovr_reg <= ovr_next;
            ist_reg <= ist_next;
        end
    end

    // ----------------------------------------
    // Interrupt mask
    // ----------------------------------------
    // Kept over a software reset, like the configuration word
    always @(posedge i_clk) begin
        if (i_rst) begin
            imk_reg <= `SLPS_RST_IRQ;
        end else if (wr && hit_imk && lo_lane) begin
            imk_reg <= i_pwdata[`SLPS_IRQ_W-1:0];
        end
    end

    // ----------------------------------------
    // Bus response
    // ----------------------------------------
    // Ready follows the taken cycle, so every access phase lasts two cycles
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_pready <= 1'b0;
        end else begin
            o_pready <= access;
        end
    end

    // Unmapped or misaligned requests answer with an error and no effect
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_pslverr <= 1'b0;
        end else begin
            o_pslverr <= bad;
        end
    end

    // Read data stands only in the ready cycle of a good read
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_prdata <= `SLPS_RST_WORD;
        end else if (rd) begin
            o_prdata <= rdata;
        end else begin
            o_prdata <= `SLPS_RST_WORD;
        end
    end

    // ----------------------------------------
    // Lane controls
    // ----------------------------------------
    // Outside serdes test mode, forced lanes are registered together with the real detection
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_receiver_detected <= `SLPS_RST_LANES;
        end else if (i_serdes_test_mode) begin
            o_receiver_detected <= i_rx_detected;
        end else begin
            o_receiver_detected <= i_rx_detected | (force_reg & valid);
        end
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_low_swing_select <= `SLPS_RST_BIT;
        end else begin
            o_low_swing_select <= swing_reg;
        end
    end

    // ----------------------------------------
    // Interrupt line
    // ----------------------------------------
    // Follows the next status value so the line rises with its flag; a
    // software reset wipes status, so the line drops with it
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= ~i_sw_rst & (|(ist_next & imk_reg));
        end
    end

endmodule

// File: dv/slps_lane_phy_chk.sv
// Port-level assertions for the lane phy register block
module slps_lane_phy_chk #(
    parameter LANES = 8
) (
    // Clock, reset and APB
    input wire i_clk,
    input wire i_rst,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [31:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire [3:0] i_pstrb,
    input wire [31:0] o_prdata,
    input wire o_pready,
    input wire o_pslverr,
    // Lane side
    input wire i_merged_mode,
    input wire i_serdes_test_mode,
    input wire [LANES-1:0] i_rx_detected,
    input wire [LANES-1:0] o_receiver_detected,
    input wire o_low_swing_select,
    input wire o_irq
);
    // ----
    // Checks
    // ----
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    wire take = i_psel && i_penable && !o_pready;
    wire cfg_wr = take && i_pwrite && i_paddr == 32'h0000_0510 && i_pstrb[2];
    // Forcing only adds lanes, so a real detection is never hidden
    chk_detect_kept: assert property (!$past(i_rst) |->
        (o_receiver_detected & $past(i_rx_detected)) == $past(i_rx_detected))
        else $error("detected lane lost");
    chk_test_exact: assert property ($past(i_serdes_test_mode) && !$past(i_rst) |->
        o_receiver_detected == $past(i_rx_detected)) else $error("force seen in test mode");
    chk_upper_plain: assert property (!$past(i_merged_mode) && !$past(i_rst) |->
        o_receiver_detected[LANES-1:4] == $past(i_rx_detected[LANES-1:4]))
        else $error("upper lanes forced while split");
    chk_swing_copy: assert property (cfg_wr |=> ##1
        o_low_swing_select == $past(i_pwdata[16], 2)) else $error("swing not updated");
    chk_ready_pulse: assert property (take |=> o_pready ##1 !o_pready)
        else $error("pready timing wrong");
    chk_idle_quiet: assert property (!o_pready |-> !o_pslverr && o_prdata == 32'h0000_0000)
        else $error("response outside pready");
    chk_bad_addr: assert property (take && i_paddr[1:0] != 2'h0 |=> o_pslverr)
        else $error("misaligned not refused");
    chk_reset_zero: assert property ($fell(i_rst) |-> !o_irq && !o_low_swing_select)
        else $error("outputs not cleared by reset");
    cover property (cfg_wr);
    cover property (o_pslverr);
    cover property (o_irq);
endmodule

bind slps_lane_phy_regs slps_lane_phy_chk #(.LANES(LANES)) i_chk (.i_clk(i_clk), .i_rst(i_rst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_merged_mode(i_merged_mode),
    .i_serdes_test_mode(i_serdes_test_mode), .i_rx_detected(i_rx_detected),
    .o_receiver_detected(o_receiver_detected), .o_low_swing_select(o_low_swing_select),
    .o_irq(o_irq));

// File: dv/slps_link_peer.sv
// Link partner model driving lane detection and lane error pulses
module slps_link_peer (
    // Clock
    input wire logic i_clk,
    // Lane signals toward the block
    output wire logic [7:0] o_det,
    output wire logic [7:0] o_disp,
    output wire logic [7:0] o_dec,
    output wire logic [7:0] o_und,
    output wire logic [7:0] o_ovr
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] det = 8'h00;
    logic [31:0] ev = 32'h0000_0000;
    assign o_det = det;
    assign {o_ovr, o_und, o_dec, o_disp} = ev;
    task automatic fire(input logic [31:0] m);
        ev <= m;
        @(posedge i_clk);
        ev <= 32'h0000_0000;
    endtask
endmodule

// File: dv/slps_lane_phy_regs_tb_top.sv
// Self-checking bench for the lane phy register block
module slps_lane_phy_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 1'h0, i_rst = 1'h1, i_sw_rst = 1'h0, i_psel = 1'h0, i_penable = 1'h0;
    logic i_pwrite = 1'h0, i_merged_mode = 1'h1, i_serdes_test_mode = 1'h0, l0, dec;
    logic [31:0] i_paddr = 32'h0, i_pwdata = 32'h0, v;
    logic [3:0] i_pstrb = 4'hf, i_ltssm_state = 4'h3;
    logic [11:0] ofs[5] = '{12'h510, 12'h51c, 12'h520, 12'h600, 12'h604};
    wire [7:0] i_rx_detected, i_disparity_err, i_decode_err, i_rx_underflow, i_rx_overflow;
    wire [7:0] o_receiver_detected;
    wire [31:0] o_prdata;
    wire o_pready, o_pslverr, o_low_swing_select, o_irq;
    logic [32:0] exp_q[$];
    int fails = 0, comparisons = 0, seed = 32'h0280f40c;
    always #50 i_clk = ~i_clk;
    slps_lane_phy_regs i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_sw_rst(i_sw_rst),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_merged_mode(i_merged_mode),
        .i_serdes_test_mode(i_serdes_test_mode), .i_ltssm_state(i_ltssm_state),
        .i_rx_detected(i_rx_detected), .i_disparity_err(i_disparity_err),
        .i_decode_err(i_decode_err), .i_rx_underflow(i_rx_underflow),
        .i_rx_overflow(i_rx_overflow), .o_receiver_detected(o_receiver_detected),
        .o_low_swing_select(o_low_swing_select), .o_irq(o_irq));
    slps_link_peer i_peer (.i_clk(i_clk), .o_det(i_rx_detected), .o_disp(i_disparity_err),
        .o_dec(i_decode_err), .o_und(i_rx_underflow), .o_ovr(i_rx_overflow));
    // ----
    // Tasks
    // ----
    task automatic check(input string nm, input logic [32:0] s, e);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic wrap_up();
        if (fails == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Expected response is {pslverr, prdata}; writes answer with zero data
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [32:0] e);
        exp_q.push_back({e[32], w ? 32'h0 : e[31:0]});
        i_psel <= 1'h1;
        i_pwrite <= w;
        i_paddr <= {20'h0, a};
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'h1;
        do @(posedge i_clk); while (o_pready !== 1'h1);
        i_psel <= 1'h0;
        i_penable <= 1'h0;
        @(posedge i_clk);
    endtask
    always @(posedge i_clk) begin
        if (o_pready === 1'h1) begin
            check("apb", {o_pslverr, o_prdata}, exp_q.pop_front());
        end
    end
    initial begin
        #(100 * 5000);
        fails++;
        wrap_up();
    end
    // ----
    // Scenarios
    // ----
    initial begin
        repeat (10) @(posedge i_clk);
        i_rst <= 1'h0;
        @(posedge i_clk);
        foreach (ofs[k]) apb(1'h0, ofs[k], 32'h0, 33'h0);
        apb(1'h0, 12'h514, 32'h0, 33'h1_0000_0000);
        apb(1'h1, 12'h512, 32'h0, 33'h1_0000_0000);
        v = $random(seed);
        i_peer.det <= v[7:0];
        apb(1'h1, 12'h510, 32'hffff_ffff, 33'h0);
        apb(1'h0, 12'h510, 32'h0, 33'h0_0001_00ff);
        check("swing", o_low_swing_select, 1'h1);
        check("detect", o_receiver_detected, 8'hff);
        i_merged_mode <= 1'h0;
        repeat (2) @(posedge i_clk);
        check("split", o_receiver_detected, {i_rx_detected[7:4], 4'hf});
        i_serdes_test_mode <= 1'h1;
        repeat (2) @(posedge i_clk);
        check("testmode", o_receiver_detected, i_rx_detected);
        i_serdes_test_mode <= 1'h0;
        i_merged_mode <= 1'h1;
        apb(1'h1, 12'h604, 32'hf, 33'h0);
        for (int s = 0; s < 7; s++) begin
            i_ltssm_state <= s[3:0];
            i_peer.fire({4{8'hff}});
            l0 = (s == 3);
            dec = (s == 2 || s == 3 || s == 5 || s == 6);
            apb(1'h0, 12'h51c, 32'h0, {9'h0, {8{dec}}, 8'h0, {8{l0}}});
            apb(1'h0, 12'h520, 32'h0, {9'h0, {8{l0}}, 8'h0, {8{l0}}});
            apb(1'h0, 12'h600, 32'h0, {29'h0, l0, l0, dec, l0});
            check("irq", o_irq, l0 | dec);
            foreach (ofs[k]) if (k > 0 && k < 4) apb(1'h1, ofs[k], 32'hffff_ffff, 33'h0);
        end
        apb(1'h1, 12'h604, 32'h0, 33'h0);
        i_ltssm_state <= 4'h3;
        i_merged_mode <= 1'h0;
        i_peer.fire(32'hff);
        apb(1'h0, 12'h51c, 32'h0, 33'hf);
        check("masked", o_irq, 1'h0);
        i_merged_mode <= 1'h1;
        fork
            apb(1'h1, 12'h51c, 32'hff, 33'h0);
            begin
                @(posedge i_clk);
                i_peer.fire(32'h1);
            end
        join
        apb(1'h0, 12'h51c, 32'h0, 33'h1);
        apb(1'h1, 12'h604, 32'hf, 33'h0);
        check("unmasked", o_irq, 1'h1);
        i_sw_rst <= 1'h1;
        @(posedge i_clk);
        i_sw_rst <= 1'h0;
        @(posedge i_clk);
        apb(1'h0, 12'h510, 32'h0, 33'h0_0001_00ff);
        apb(1'h0, 12'h51c, 32'h0, 33'h0);
        check("cleared", o_irq, 1'h0);
        wrap_up();
    end
endmodule
